/* design/port_output_stop_params.svh */
// Purpose: offsets, fields, resets and counts of the stop block
// Assumes: byte addresses on a 32-bit APB, one register per word
// Notes:   definitions only
`ifndef PORT_OUTPUT_STOP_PARAMS_SVH
`define PORT_OUTPUT_STOP_PARAMS_SVH

// register byte offsets
`define OFS_INPUT_TEN 8'h00
`define OFS_SW_STOP 8'h04
`define OFS_PAIR_HIZ 8'h08
`define OFS_PAIR_EXT 8'h0C
`define OFS_CH0_EXT 8'h10
`define OFS_CMP_FLAGS 8'h14
`define OFS_CMP_SEL 8'h18
`define OFS_MISC_STAT 8'h1C
`define OFS_CMP_EXT0 8'h20
`define NUM_CMP_EXT 9

// input-ten control/status fields
`define POS_MODE 0
`define POS_COUNT 4
`define POS_INVERT 8
`define POS_IRQ_EN 9
`define POS_TEN_FLAG 12

// misc status fields
`define POS_SHORT_FLAG 0
`define POS_OSC_FLAG 1

// stop-input mode codes
`define MODE_EDGE 4'h0
`define MODE_DIV8 4'h1
`define MODE_DIV16 4'h2
`define MODE_DIV128 4'h3
`define MODE_DIV1 4'h4
`define MODE_DIV2 4'h5
`define MODE_DIV4 4'h6

// reset values
`define RST_INPUT_TEN 16'h0000
`define RST_SW_STOP 16'h0000
`define RST_FIELD5 5'h00
`define RST_FIELD3 3'h0

// prescaler bits for clock/128
`define DIV_BITS 7
// count field zero means sixteen
`define COUNT_ZERO_MEANS 5'h10

`endif

/* design/port_output_stop_pkg.sv */
// Purpose: shared types of the output-stop controller
// Assumes: nothing beyond SystemVerilog packed types
// Notes:   constants live in the params header
package port_output_stop_pkg;

    // one stop (high-impedance) request per controlled output group
    typedef struct packed {
        logic grp7;   // pwm group 7
        logic grp46;  // pwm groups 4 to 6
        logic grp02;  // pwm groups 0 to 2
        logic grp23;  // pwm groups 2 and 3
        logic grp01;  // pwm groups 0 and 1
        logic ch9;    // motor channel 9
        logic p7bd;   // motor pair seven b/d
        logic p7ac;   // motor pair seven a/c
        logic p6bd;   // motor pair six b/d
        logic ch0;    // motor channel zero
        logic pair34; // motor complementary pairs 3/4
    } stop_t;

    // apb request as seen by the slave
    typedef struct packed {
        logic sel;
        logic enable;
        logic write;
        logic [7:0] addr;
        logic [31:0] wdata;
    } apb_req_t;

endpackage

/* design/stop_sample_divider.sv */
// Purpose: one-cycle sample ticks at the clock divided by 2..128
// Assumes: single clock, ticks used as clock enables
// Notes:   free running from reset
`include "port_output_stop_params.svh"

module stop_sample_divider (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    output logic tick2_o,
    output logic tick4_o,
    output logic tick8_o,
    output logic tick16_o,
    output logic tick128_o
);
    logic [`DIV_BITS-1:0] div_reg; // free running prescaler

    // prescaler count
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_reg + 1'b1;
        end
    end

    // a tick when the low bits are all ones
    assign tick2_o = div_reg[0];
    assign tick4_o = &div_reg[1:0];
    assign tick8_o = &div_reg[2:0];
    assign tick16_o = &div_reg[3:0];
    assign tick128_o = &div_reg[6:0];
endmodule // stop_sample_divider

/* design/stop_input_filter.sv */
// Purpose: edge or consecutive-level detection of the stop input
// Assumes: pin synchronous to the clock; tick_i selects sample rate
// Notes:   accept_o pulses once per edge; in sampling it repeats on each tick while the run stays at the count
`include "port_output_stop_params.svh"

module stop_input_filter (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic pin_i,
    input wire logic invert_i,
    input wire logic edge_mode_i,
    input wire logic sample_mode_i,
    input wire logic tick_i,
    input wire logic [3:0] count_i,
    output logic accept_o
);
    logic level;            // input after optional inversion
    logic prev_reg;         // level seen last clock
    logic [4:0] run_reg;    // consecutive matching samples
    logic [4:0] need;       // samples required

    assign level = pin_i ^ invert_i;
    // field zero stands for sixteen samples
    assign need = (count_i == 4'h0) ? `COUNT_ZERO_MEANS : {1'b0, count_i};

    // previous level for edge detection
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prev_reg <= 1'b1;
        end else begin
            prev_reg <= level;
        end
    end

    // run counter, restarts on any mismatch
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            run_reg <= '0;
        end else if (!sample_mode_i) begin
            run_reg <= '0;
        end else if (tick_i) begin
            if (level) begin
                run_reg <= '0;
            end else if (run_reg < need) begin
                run_reg <= run_reg + 5'h01;
            end
        end
    end

    // accept on either edge, or when the run reaches the count
    always_comb begin
        accept_o = 1'b0;
        if (edge_mode_i) begin
            accept_o = level ^ prev_reg;
        end else if (sample_mode_i) begin
            accept_o = tick_i && !level && (run_reg + 5'h01 >= need);
        end
    end
endmodule // stop_input_filter

/* design/port_output_stop_control.sv */
// Purpose: forces timer output groups into the stopped state
// Assumes: apb slave with no wait states; all inputs synchronous
// Notes:   stop outputs are registered; flags hold until cleared
//
// Design decisions made here: the placing of the registers and register access over APB.
`include "port_output_stop_params.svh"

// Summary of operation
// - mode zero: accept either input edge
// - codes 1-3 sample at clock/8,/16,/128
// - codes 4-6 sample at clock/1,/2,/4
// - accept after consecutive matching samples
// - four-bit field sets sample count
// - invert bit flips input polarity
// - sixteen-bit software stop register
// - software bits stop every output group except pair34 and ch0
// - per-pair high-impedance enables
// - extend flags into pair stop
// - extend flags into channel-zero stop
// - comparator 3-5 detection flags
// - per-comparator stop enables
// - nine comparator request-extension selects
// - accepted request stops all targets, the p6bd/p7ac/p7bd groups only when hiz-enabled
// - simultaneous active pair levels stop pairs
// - interrupt on input-ten or pair short stop
module port_output_stop_control #(
    parameter int NUM_PAIRS = 6 // monitored complementary pairs
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic stop_request_input_ten_i,
    input wire logic osc_stop_i,
    input wire logic [5:0] ext_flags_i,
    input wire logic [2:0] cmp_detect_i,
    input wire logic [NUM_PAIRS-1:0] pair_a_i,
    input wire logic [NUM_PAIRS-1:0] pair_b_i,
    output port_output_stop_pkg::stop_t stop_o,
    output logic stop_irq_o
);
    port_output_stop_pkg::apb_req_t req; // bundled bus request
    logic wr_en;              // write takes effect this edge
    logic rd_setup;           // read setup cycle
    logic [15:0] ten_reg;     // input-ten control bits
    logic ten_flag_reg;       // input-ten detection flag
    logic [15:0] sw_stop_reg; // software stop enables
    logic [2:0] pair_hiz_reg; // pair hiz enables
    logic [4:0] pair_ext_reg; // flag extension into pair stop
    logic [4:0] ch0_ext_reg;  // flag extension into ch0 stop
    logic [2:0] cmp_flag_reg; // comparator detection flags
    logic [2:0] cmp_sel_reg;  // comparator stop enables
    logic short_flag_reg;     // pair short detected
    logic osc_flag_reg;       // oscillation stop detected
    logic [2:0] cmp_ext_reg [`NUM_CMP_EXT]; // extension selects
    logic [31:0] rd_next;     // read mux
    logic [31:0] rdata_reg;   // captured read data
    logic hit;                // address is mapped
    logic t2, t4, t8, t16, t128; // prescaler ticks
    logic tick;               // selected sample tick
    logic edge_mode;          // edge detection selected
    logic sample_mode;        // level sampling selected
    logic accept;             // input-ten request accepted
    logic short_now;          // any pair drives both active
    logic all_stop;           // stop every target (p6bd/p7ac/p7bd when hiz-enabled)
    logic [`NUM_CMP_EXT-1:0] ext_hit; // routed comparator requests
    port_output_stop_pkg::stop_t stop_next; // next stop pattern

    // is the address one of the extension selects
    function automatic logic is_ext(input logic [7:0] a);
        is_ext = (a >= `OFS_CMP_EXT0) &&
            (a < `OFS_CMP_EXT0 + 8'(4 * `NUM_CMP_EXT)) && (a[1:0] == 2'b00);
    endfunction

    // index of an extension select from its address
    function automatic logic [3:0] ext_idx(input logic [7:0] a);
        logic [7:0] d;
        d = a - `OFS_CMP_EXT0;
        ext_idx = d[5:2];
    endfunction

    // write-zero-clears flag; a new event wins over the clear
    function automatic logic sticky(input logic cur, input logic set,
                                    input logic clr_wr, input logic wbit);
        sticky = set | (cur & !(clr_wr & !wbit));
    endfunction

    assign req = '{sel: psel_i, enable: penable_i, write: pwrite_i,
                   addr: paddr_i, wdata: pwdata_i};
    assign wr_en = req.sel & req.enable & req.write;
    assign rd_setup = req.sel & !req.enable & !req.write;

    // mapped register decode
    assign hit = is_ext(req.addr) || (req.addr <= `OFS_MISC_STAT &&
        req.addr[1:0] == 2'b00);

    // no wait states; unmapped access answers with an error
    assign pready_o = 1'b1;
    assign pslverr_o = req.sel & req.enable & !hit;
    assign prdata_o = rdata_reg;

    // sample rate divider
    stop_sample_divider u_div (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .tick2_o(t2),
        .tick4_o(t4),
        .tick8_o(t8),
        .tick16_o(t16),
        .tick128_o(t128)
    );

    // choose the sample tick from the mode field
    always_comb begin
        edge_mode = 1'b0;
        sample_mode = 1'b1;
        tick = 1'b0;
        case (ten_reg[`POS_MODE +: 4])
            `MODE_EDGE: begin
                edge_mode = 1'b1;
                sample_mode = 1'b0;
            end
            `MODE_DIV8: tick = t8;
            `MODE_DIV16: tick = t16;
            `MODE_DIV128: tick = t128;
            `MODE_DIV1: tick = 1'b1;
            `MODE_DIV2: tick = t2;
            `MODE_DIV4: tick = t4;
            default: begin
                sample_mode = 1'b0;
            end
        endcase
    end

    // input-ten detection
    stop_input_filter u_filt (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .pin_i(stop_request_input_ten_i),
        .invert_i(ten_reg[`POS_INVERT]),
        .edge_mode_i(edge_mode),
        .sample_mode_i(sample_mode),
        .tick_i(tick),
        .count_i(ten_reg[`POS_COUNT +: 4]),
        .accept_o(accept)
    );

    // control fields of the input-ten register
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ten_reg <= `RST_INPUT_TEN;
        end else if (wr_en && req.addr == `OFS_INPUT_TEN) begin
            ten_reg <= {6'h00, req.wdata[9:0]};
        end
    end

    // software stop and extension controls
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sw_stop_reg <= `RST_SW_STOP;
            pair_hiz_reg <= `RST_FIELD3;
            pair_ext_reg <= `RST_FIELD5;
            ch0_ext_reg <= `RST_FIELD5;
            cmp_sel_reg <= `RST_FIELD3;
        end else if (wr_en) begin
            case (req.addr)
                `OFS_SW_STOP: sw_stop_reg <= req.wdata[15:0];
                `OFS_PAIR_HIZ: pair_hiz_reg <= req.wdata[2:0];
                `OFS_PAIR_EXT: pair_ext_reg <= req.wdata[4:0];
                `OFS_CH0_EXT: ch0_ext_reg <= req.wdata[4:0];
                `OFS_CMP_SEL: cmp_sel_reg <= req.wdata[2:0];
                default: begin
                end
            endcase
        end
    end

    // comparator request-extension selects
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int m = 0; m < `NUM_CMP_EXT; m++) begin
                cmp_ext_reg[m] <= `RST_FIELD3;
            end
        end else if (wr_en && is_ext(req.addr)) begin
            cmp_ext_reg[ext_idx(req.addr)] <= req.wdata[2:0];
        end
    end

    // any monitored pair driving both pins active
    assign short_now = |(pair_a_i & pair_b_i);

    // sticky flags: write zero clears, a new event wins
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ten_flag_reg <= 1'b0;
            cmp_flag_reg <= '0;
            short_flag_reg <= 1'b0;
            osc_flag_reg <= 1'b0;
        end else begin
            ten_flag_reg <= sticky(ten_flag_reg, accept,
                wr_en && req.addr == `OFS_INPUT_TEN,
                req.wdata[`POS_TEN_FLAG]);
            for (int c = 0; c < 3; c++) begin
                cmp_flag_reg[c] <= sticky(cmp_flag_reg[c],
                    cmp_detect_i[c], wr_en && req.addr == `OFS_CMP_FLAGS,
                    req.wdata[c]);
            end
            short_flag_reg <= sticky(short_flag_reg, short_now,
                wr_en && req.addr == `OFS_MISC_STAT,
                req.wdata[`POS_SHORT_FLAG]);
            osc_flag_reg <= sticky(osc_flag_reg, osc_stop_i,
                wr_en && req.addr == `OFS_MISC_STAT,
                req.wdata[`POS_OSC_FLAG]);
        end
    end

    // comparator requests routed to single targets
    always_comb begin
        for (int m = 0; m < `NUM_CMP_EXT; m++) begin
            ext_hit[m] = |(cmp_flag_reg & cmp_ext_reg[m]);
        end
    end

    // accepted requests stop every target; p6bd/p7ac/p7bd only with their hiz enable
    assign all_stop = ten_flag_reg | osc_flag_reg |
        |(cmp_flag_reg & cmp_sel_reg);

    // stop pattern for each output group
    always_comb begin
        stop_next = '0;
        stop_next.pair34 = all_stop | short_flag_reg | ext_hit[0] |
            |(pair_ext_reg & {ext_flags_i[5:3], ext_flags_i[1:0]});
        stop_next.ch0 = all_stop | ext_hit[1] |
            |(ch0_ext_reg & ext_flags_i[5:1]);
        stop_next.p6bd = sw_stop_reg[0] | (pair_hiz_reg[2] &
            (all_stop | short_flag_reg | ext_hit[2]));
        stop_next.p7ac = sw_stop_reg[0] | (pair_hiz_reg[1] &
            (all_stop | short_flag_reg | ext_hit[3]));
        stop_next.p7bd = sw_stop_reg[0] | (pair_hiz_reg[0] &
            (all_stop | short_flag_reg | ext_hit[4]));
        stop_next.ch9 = sw_stop_reg[3] | all_stop | ext_hit[5];
        stop_next.grp01 = sw_stop_reg[1] | all_stop | ext_hit[6];
        stop_next.grp23 = sw_stop_reg[2] | all_stop | ext_hit[7];
        stop_next.grp02 = sw_stop_reg[4] | all_stop | ext_hit[8];
        stop_next.grp46 = sw_stop_reg[5] | all_stop;
        stop_next.grp7 = sw_stop_reg[6] | all_stop;
    end

    // registered stop outputs and interrupt
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stop_o <= '0;
            stop_irq_o <= 1'b0;
        end else begin
            stop_o <= stop_next;
            stop_irq_o <= ten_reg[`POS_IRQ_EN] &
                (ten_flag_reg | short_flag_reg);
        end
    end

    // read mux
    always_comb begin
        rd_next = 32'h0000_0000;
        if (is_ext(req.addr)) begin
            rd_next[2:0] = cmp_ext_reg[ext_idx(req.addr)];
        end else begin
            case (req.addr)
                `OFS_INPUT_TEN: begin
                    rd_next[15:0] = ten_reg;
                    rd_next[`POS_TEN_FLAG] = ten_flag_reg;
                end
                `OFS_SW_STOP: rd_next[15:0] = sw_stop_reg;
                `OFS_PAIR_HIZ: rd_next[2:0] = pair_hiz_reg;
                `OFS_PAIR_EXT: rd_next[4:0] = pair_ext_reg;
                `OFS_CH0_EXT: rd_next[4:0] = ch0_ext_reg;
                `OFS_CMP_FLAGS: rd_next[2:0] = cmp_flag_reg;
                `OFS_CMP_SEL: rd_next[2:0] = cmp_sel_reg;
                `OFS_MISC_STAT: rd_next[1:0] = {osc_flag_reg, short_flag_reg};
                default: rd_next = 32'h0000_0000;
            endcase
        end
    end

    // read data captured in the setup cycle
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_reg <= 32'h0000_0000;
        end else if (rd_setup) begin
            rdata_reg <= rd_next;
        end
    end
endmodule // port_output_stop_control

/* verification/port_output_stop_checker.sv */
// Purpose: port-level assertions for the output-stop controller
// Assumes: bound into every controller instance
// Notes:   the grp7 stop output falls only after a register write
`include "port_output_stop_params.svh"

module port_output_stop_checker #(
    parameter int NUM_PAIRS = 6 // monitored pairs
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic stop_request_input_ten_i,
    input wire logic osc_stop_i,
    input wire logic [5:0] ext_flags_i,
    input wire logic [2:0] cmp_detect_i,
    input wire logic [NUM_PAIRS-1:0] pair_a_i,
    input wire logic [NUM_PAIRS-1:0] pair_b_i,
    input wire port_output_stop_pkg::stop_t stop_o,
    input wire logic stop_irq_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // access phase of a write
    logic wr;
    assign wr = psel_i && penable_i && pwrite_i;
    // write to the software stop word
    logic sw_wr;
    assign sw_wr = wr && (paddr_i == `OFS_SW_STOP);

    chk_osc_stops_all: assert property (
        osc_stop_i |-> ##[1:3] (stop_o.grp7 && stop_o.ch0 && stop_o.pair34))
        else $error("osc stop ignored");
    chk_short_pair: assert property (
        (pair_a_i[0] && pair_b_i[0]) |-> ##[1:3] stop_o.pair34)
        else $error("short ignored");
    chk_irq_with_stop: assert property (
        stop_irq_o |-> (stop_o != '0))
        else $error("irq without stop");
    chk_stop_sticky: assert property (
        $fell(stop_o.grp7) |-> ($past(wr) || $past(wr, 2)))
        else $error("stop dropped unasked");
    chk_sw_grp7: assert property (
        (sw_wr && pwdata_i[6]) |-> ##[1:2] stop_o.grp7)
        else $error("sw group 7 ignored");
    chk_sw_pairs: assert property (
        (sw_wr && pwdata_i[0]) |-> ##[1:2]
            (stop_o.p6bd && stop_o.p7ac && stop_o.p7bd))
        else $error("sw pairs ignored");
    chk_unmapped_err: assert property (
        (psel_i && penable_i && paddr_i > 8'h40) |-> pslverr_o)
        else $error("unmapped not refused");
    chk_mapped_ok: assert property (
        (psel_i && penable_i && paddr_i[1:0] == 2'b00 && paddr_i <= 8'h40)
            |-> !pslverr_o)
        else $error("mapped refused");

    // main scenarios seen
    cover property (osc_stop_i);
    cover property (stop_irq_o);
    cover property ($rose(stop_o.pair34) && !stop_o.grp7);
endmodule // port_output_stop_checker

bind port_output_stop_control port_output_stop_checker #(
    .NUM_PAIRS(NUM_PAIRS)
) u_chk (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o),
    .stop_request_input_ten_i(stop_request_input_ten_i),
    .osc_stop_i(osc_stop_i), .ext_flags_i(ext_flags_i),
    .cmp_detect_i(cmp_detect_i), .pair_a_i(pair_a_i), .pair_b_i(pair_b_i),
    .stop_o(stop_o), .stop_irq_o(stop_irq_o)
);

/* verification/timer_pins_model.sv */
// Purpose: timer pins, stop input and detectors around the controller
// Assumes: the bench calls drive to change levels
// Notes:   pairs idle complementary, the stop input idles high
module timer_pins_model (
    input wire logic sys_clk_i,
    output logic stop_pin_o,
    output logic osc_stop_o,
    output logic [5:0] ext_flags_o,
    output logic [2:0] cmp_detect_o,
    output logic [5:0] pair_a_o,
    output logic [5:0] pair_b_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle levels from time zero
    initial begin
        stop_pin_o = 1'b1;
        osc_stop_o = 1'b0;
        ext_flags_o = 6'h00;
        cmp_detect_o = 3'h0;
        pair_a_o = 6'h2A;
        pair_b_o = 6'h15;
    end

    // new levels just after a rising edge; short drives both legs high
    task automatic drive(input logic pin, input logic osc,
            input logic [5:0] ext, input logic [2:0] cmp,
            input logic [5:0] short);
        @(posedge sys_clk_i);
        stop_pin_o <= pin;
        osc_stop_o <= osc;
        ext_flags_o <= ext;
        cmp_detect_o <= cmp;
        pair_a_o <= 6'h2A | short;
        pair_b_o <= 6'h15 | short;
    endtask
endmodule // timer_pins_model

/* verification/tb_top.sv */
// Purpose: register-level tests of the output-stop controller
// Assumes: APB slave, registered stop outputs
// Notes:   expectations follow the stop_t bit order
`include "port_output_stop_params.svh"

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pready, pslverr, stop_irq, pin, osc, last_err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rdata;
    logic [5:0] ext, pa, pb;
    logic [2:0] cmp;
    port_output_stop_pkg::stop_t stop;
    int bad_count = 0, checked = 0;
    // stop groups per software bit
    logic [10:0] sw_mask [7] = '{11'h01C, 11'h040, 11'h080, 11'h020,
        11'h100, 11'h200, 11'h400};
    // divisor per sampling code 1..6
    int divs [6] = '{8, 16, 128, 1, 2, 4};

    always #2 clk = ~clk;

    port_output_stop_control dut (.sys_clk_i(clk), .rst_n_i(rst_n),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr),
        .stop_request_input_ten_i(pin), .osc_stop_i(osc),
        .ext_flags_i(ext), .cmp_detect_i(cmp), .pair_a_i(pa),
        .pair_b_i(pb), .stop_o(stop), .stop_irq_o(stop_irq));
    timer_pins_model pins (.sys_clk_i(clk), .stop_pin_o(pin),
        .osc_stop_o(osc), .ext_flags_o(ext), .cmp_detect_o(cmp),
        .pair_a_o(pa), .pair_b_o(pb));

    // compare and count
    task automatic check(input string what, input logic [31:0] seen,
            input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one APB transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rdata = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // all registers use the low half-word only
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        apb(1'b1, a, {16'h0000, d});
    endtask

    task automatic rd(input string what, input logic [7:0] a,
            input logic [15:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(what, rdata, {16'h0000, exp});
    endtask

    // wait a bounded time for an exact stop pattern
    task automatic see(input string what, input logic [10:0] exp,
            input int lim);
        for (int n = 0; n < lim && stop !== exp; n++) @(negedge clk);
        check(what, {21'h0, stop}, {21'h0, exp});
    endtask

    // outputs must still run after n cycles
    task automatic hold_zero(input string what, input int n);
        repeat (n) @(negedge clk);
        check(what, {21'h0, stop}, 32'h0000_0000);
    endtask

    task automatic idle();
        pins.drive(1'b1, 1'b0, 6'h00, 3'h0, 6'h00);
    endtask

    task automatic low();
        pins.drive(1'b0, 1'b0, 6'h00, 3'h0, 6'h00);
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // hang guard
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        complete_run();
    end

    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rd("ten reset", `OFS_INPUT_TEN, `RST_INPUT_TEN);
        rd("sw reset", `OFS_SW_STOP, `RST_SW_STOP);
        rd("unmapped", 8'h44, 16'h0000);
        check("unmapped err", {31'h0, last_err}, 32'h0000_0001);
        // each software stop bit alone
        for (int i = 0; i < 7; i++) begin
            wr(`OFS_SW_STOP, 16'h0001 << i);
            see("sw stop", sw_mask[i], 4);
            rd("sw back", `OFS_SW_STOP, 16'h0001 << i);
        end
        wr(`OFS_SW_STOP, 16'hFF80);
        rd("sw upper", `OFS_SW_STOP, 16'hFF80);
        wr(`OFS_SW_STOP, 16'h0000);
        see("sw off", 11'h000, 4);
        // edge mode: falling, then rising, interrupt on
        wr(`OFS_PAIR_HIZ, 16'h0007);
        wr(`OFS_INPUT_TEN, 16'h0200);
        low();
        see("fall", 11'h7FF, 6);
        check("irq", {31'h0, stop_irq}, 32'h0000_0001);
        rd("ten flag", `OFS_INPUT_TEN, 16'h1200);
        wr(`OFS_INPUT_TEN, 16'h0200);
        see("flag clr", 11'h000, 6);
        idle();
        see("rise", 11'h7FF, 6);
        wr(`OFS_INPUT_TEN, 16'h0200);
        // level sampling at every rate, two samples; clearing in edge
        // mode between rates so no run carries into the next rate
        for (int i = 0; i < 6; i++) begin
            wr(`OFS_INPUT_TEN, 16'h0021 + 16'(i));
            low();
            hold_zero("early", divs[i]);
            see("sampled", 11'h7FF, 2 * divs[i] + 8);
            idle();
            wr(`OFS_INPUT_TEN, 16'h0020);
            see("smp clr", 11'h000, 6);
        end
        // a run of two against a count of three restarts
        wr(`OFS_INPUT_TEN, 16'h0034);
        low();
        low();
        idle();
        hold_zero("short run", 6);
        low();
        see("full run", 11'h7FF, 10);
        idle();
        wr(`OFS_INPUT_TEN, 16'h0034);
        // inverted input: the idle high level requests
        wr(`OFS_INPUT_TEN, 16'h0114);
        see("inverted", 11'h7FF, 8);
        wr(`OFS_INPUT_TEN, 16'h1014);
        wr(`OFS_INPUT_TEN, 16'h0014);
        see("inv clr", 11'h000, 6);
        // comparator 3 enabled, comparator 4 masked
        wr(`OFS_CMP_SEL, 16'h0001);
        pins.drive(1'b1, 1'b0, 6'h00, 3'h1, 6'h00);
        see("cmp3", 11'h7FF, 6);
        rd("cmp3 flag", `OFS_CMP_FLAGS, 16'h0001);
        pins.drive(1'b1, 1'b0, 6'h00, 3'h2, 6'h00);
        wr(`OFS_CMP_FLAGS, 16'h0000);
        hold_zero("cmp4 masked", 4);
        rd("cmp4 flag", `OFS_CMP_FLAGS, 16'h0002);
        // comparator 4 routed to each extension target
        for (int m = 0; m < 9; m++) begin
            wr(`OFS_CMP_EXT0 + 8'(4 * m), 16'h0002);
            see("cmp ext", 11'h001 << m, 4);
            wr(`OFS_CMP_EXT0 + 8'(4 * m), 16'h0000);
        end
        idle();
        wr(`OFS_CMP_FLAGS, 16'h0000);
        see("cmp clr", 11'h000, 6);
        // shorted pair, without and with pair enables
        wr(`OFS_PAIR_HIZ, 16'h0000);
        pins.drive(1'b1, 1'b0, 6'h00, 3'h0, 6'h01);
        see("short", 11'h001, 6);
        rd("short flag", `OFS_MISC_STAT, 16'h0001);
        wr(`OFS_PAIR_HIZ, 16'h0005);
        see("short hiz", 11'h015, 6);
        idle();
        wr(`OFS_MISC_STAT, 16'h0000);
        see("short clr", 11'h000, 6);
        // other input flags extend pair and channel-zero stops
        wr(`OFS_PAIR_EXT, 16'h0001);
        pins.drive(1'b1, 1'b0, 6'h01, 3'h0, 6'h00);
        see("pair ext", 11'h001, 6);
        idle();
        wr(`OFS_PAIR_EXT, 16'h0000);
        see("pair off", 11'h000, 6);
        wr(`OFS_CH0_EXT, 16'h0002);
        pins.drive(1'b1, 1'b0, 6'h04, 3'h0, 6'h00);
        see("ch0 ext", 11'h002, 6);
        idle();
        wr(`OFS_CH0_EXT, 16'h0000);
        // oscillation stop
        wr(`OFS_PAIR_HIZ, 16'h0007);
        pins.drive(1'b1, 1'b1, 6'h00, 3'h0, 6'h00);
        idle();
        see("osc", 11'h7FF, 6);
        rd("osc flag", `OFS_MISC_STAT, 16'h0002);
        wr(`OFS_MISC_STAT, 16'h0000);
        see("osc clr", 11'h000, 6);
        complete_run();
    end
endmodule // tb_top
